// ### core/fmsp_pkg.sv
// constants and types for the four-mode serial port
package fmsp_pkg;
	// register word indices; byte address is four times the index
	localparam logic [5:0] IDX_CTRL_HIGH   = 6'h14;
	localparam logic [5:0] IDX_CTRL_LOW    = 6'h15;
	localparam logic [5:0] IDX_DATA_BUF    = 6'h16;
	localparam logic [5:0] IDX_BAUD_DIV    = 6'h17;
	// serial_control_high fields
	localparam int CH_MODE_HI  = 7;
	localparam int CH_MODE_LO  = 6;
	localparam int CH_MCE      = 5;
	localparam int CH_RX_EN    = 4;
	localparam int CH_TB8      = 3;
	localparam int CH_RB8      = 2;
	localparam int CH_RX_IE    = 1;
	localparam int CH_RX_PEND  = 0;
	// serial_control_low fields
	localparam int CL_TX_PAR   = 7;
	localparam int CL_RX_PAR   = 6;
	localparam int CL_CLK_HI   = 3;
	localparam int CL_CLK_LO   = 2;
	localparam int CL_TX_IE    = 1;
	localparam int CL_TX_PEND  = 0;
	// reset values
	localparam logic [7:0] CTRL_HIGH_RST = 8'h00;
	localparam logic [7:0] CTRL_LOW_RST  = 8'h00;
	localparam logic [7:0] DATA_BUF_RST  = 8'h00;
	localparam logic [7:0] BAUD_DIV_RST  = 8'h00;
	// operating modes
	localparam logic [1:0] MODE_SYNC       = 2'h0;
	localparam logic [1:0] MODE_ASYNC8     = 2'h1;
	localparam logic [1:0] MODE_NINE_FIXED = 2'h2;
	localparam logic [1:0] MODE_NINE_VAR   = 2'h3;
	// bit timing: sixteen ticks per bit
	localparam logic [3:0] SUB_MID      = 4'h7;
	localparam logic [3:0] SUB_LAST     = 4'hf;
	localparam logic [2:0] BIT_LAST     = 3'h7;
	localparam logic [7:0] FIXED_DIV    = 8'h00;
	// state machines
	typedef enum logic [5:0] {
		TX_IDLE  = 6'h01,
		TX_START = 6'h02,
		TX_DATA  = 6'h04,
		TX_NINTH = 6'h08,
		TX_STOP  = 6'h10,
		TX_SYNC  = 6'h20
	} fmsp_tx_state_t;
	typedef enum logic [4:0] {
		RX_IDLE  = 5'h01,
		RX_START = 5'h02,
		RX_DATA  = 5'h04,
		RX_NINTH = 5'h08,
		RX_STOP  = 5'h10
	} fmsp_rx_state_t;
endpackage

// ### core/fmsp_top.sv
// four-mode serial port with classic wishbone register slave
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/10ps
// Contract
// - one synchronous and three asynchronous modes
// - data write loads tx, read gives rx
// - next reception may start before read
// - any data register write starts transmission
// - sync receive starts when pending clear, enabled
// - async receive starts on low start bit
// - high control holds mode, filter, enable, ninths
// - high control at 14h, resets to 00h
// - low control at 15h, resets to 00h
// - completion sets pending, irq when enabled
// - sync rx pending after eighth bit in
// - 8-bit async rx pending at stop midpoint
// - 9-bit rx pending at ninth bit midpoint
// - sync tx pending after eighth bit out
// - async tx pending at stop bit start
// - pending flags cleared only by software
// - sync rate is source over 16(div+1)
// - fixed 9-bit rate is source over 16
// - variable async rate is source over 16(div+1)
// - sync data on in pin, clock out
// - 8-bit frame: start, eight lsb-first, stop
// - 9-bit frame adds ninth bit, stop ignored
// - filter drops frames with ninth bit zero
module fmsp_top (
	// clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// wishbone slave
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic             wb_ack_o,
	// serial pins
	input  wire logic        serial_in_pin_i,
	output logic             serial_in_pin_o,
	output logic             serial_in_pin_oe_o,
	output logic             serial_out_pin_o,
	// interrupt requests
	output logic             rx_irq_o,
	output logic             tx_irq_o
);

	logic                   ack_r;
	logic [31:0]            dat_r;
	logic [1:0]             mode_r;
	logic                   mce_r;
	logic                   rx_en_r;
	logic                   tb8_r;
	logic                   rb8_r;
	logic                   rx_ie_r;
	logic                   rx_pend_r;
	logic                   tx_par_r;
	logic                   rx_par_r;
	logic [1:0]             clk_sel_r;
	logic                   tx_ie_r;
	logic                   tx_pend_r;
	logic [7:0]             rx_buf_r;
	logic [7:0]             baud_div_r;
	logic [2:0]             pre_cnt_r;
	logic [7:0]             div_cnt_r;
	logic                   rx_irq_r;
	logic                   tx_irq_r;
	fmsp_pkg::fmsp_tx_state_t tx_state_r;
	logic [3:0]             tx_sub_r;
	logic [2:0]             tx_bit_r;
	logic [7:0]             tx_shift_r;
	logic                   sync_rx_r;
	logic                   sync_samp_r;
	logic                   out_r;
	logic                   din_o_r;
	logic                   din_oe_r;
	logic                   tx_set_r;
	logic                   rx0_set_r;
	fmsp_pkg::fmsp_rx_state_t rx_state_r;
	logic [3:0]             rx_sub_r;
	logic [2:0]             rx_bit_r;
	logic [7:0]             rx_shift_r;
	logic                   rx_nine_r;
	logic                   rx_set_r;
	logic                   rx_keep_nine_r;

	logic                   req;
	logic                   wr_en;
	logic [5:0]             idx;
	logic                   wr_high;
	logic                   wr_low;
	logic                   tx_go;
	logic [2:0]             pre_mask;
	logic                   src_tick;
	logic [7:0]             div_lim;
	logic                   tick16;
	logic                   nine_mode;
	logic                   tx_bit_end;
	logic                   rx_mid;
	logic [7:0]             rd_byte;

	assign req      = wb_cyc_i & wb_stb_i;
	assign idx      = wb_adr_i[7:2];
	assign wr_en    = req & wb_we_i & ack_r & wb_sel_i[0];
	assign wr_high  = wr_en & (idx == fmsp_pkg::IDX_CTRL_HIGH);
	assign wr_low   = wr_en & (idx == fmsp_pkg::IDX_CTRL_LOW);
	assign tx_go    = wr_en & (idx == fmsp_pkg::IDX_DATA_BUF);
	assign nine_mode = mode_r[1];

	// read multiplexer
	always_comb begin
		case (idx)
			fmsp_pkg::IDX_CTRL_HIGH: rd_byte = {mode_r, mce_r, rx_en_r, tb8_r, rb8_r,
				rx_ie_r, rx_pend_r};
			fmsp_pkg::IDX_CTRL_LOW: rd_byte = {tx_par_r, rx_par_r, 2'b00, clk_sel_r,
				tx_ie_r, tx_pend_r};
			fmsp_pkg::IDX_DATA_BUF: rd_byte = rx_buf_r;
			fmsp_pkg::IDX_BAUD_DIV: rd_byte = baud_div_r;
			default: rd_byte = 8'h00;
		endcase
	end

	// bus handshake, one wait cycle, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_r <= req & ~ack_r;
			if (req & ~ack_r) begin
				dat_r <= {24'h00_0000, rd_byte};
			end
		end
	end

	// high control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_r  <= fmsp_pkg::CTRL_HIGH_RST[fmsp_pkg::CH_MODE_HI:fmsp_pkg::CH_MODE_LO];
			mce_r   <= fmsp_pkg::CTRL_HIGH_RST[fmsp_pkg::CH_MCE];
			rx_en_r <= fmsp_pkg::CTRL_HIGH_RST[fmsp_pkg::CH_RX_EN];
			tb8_r   <= fmsp_pkg::CTRL_HIGH_RST[fmsp_pkg::CH_TB8];
			rx_ie_r <= fmsp_pkg::CTRL_HIGH_RST[fmsp_pkg::CH_RX_IE];
		end else if (ce_i && wr_high) begin
			mode_r  <= wb_dat_i[fmsp_pkg::CH_MODE_HI:fmsp_pkg::CH_MODE_LO];
			mce_r   <= wb_dat_i[fmsp_pkg::CH_MCE];
			rx_en_r <= wb_dat_i[fmsp_pkg::CH_RX_EN];
			tb8_r   <= wb_dat_i[fmsp_pkg::CH_TB8];
			rx_ie_r <= wb_dat_i[fmsp_pkg::CH_RX_IE];
		end
	end

	// low control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_par_r  <= fmsp_pkg::CTRL_LOW_RST[fmsp_pkg::CL_TX_PAR];
			rx_par_r  <= fmsp_pkg::CTRL_LOW_RST[fmsp_pkg::CL_RX_PAR];
			clk_sel_r <= fmsp_pkg::CTRL_LOW_RST[fmsp_pkg::CL_CLK_HI:fmsp_pkg::CL_CLK_LO];
			tx_ie_r   <= fmsp_pkg::CTRL_LOW_RST[fmsp_pkg::CL_TX_IE];
		end else if (ce_i && wr_low) begin
			tx_par_r  <= wb_dat_i[fmsp_pkg::CL_TX_PAR];
			rx_par_r  <= wb_dat_i[fmsp_pkg::CL_RX_PAR];
			clk_sel_r <= wb_dat_i[fmsp_pkg::CL_CLK_HI:fmsp_pkg::CL_CLK_LO];
			tx_ie_r   <= wb_dat_i[fmsp_pkg::CL_TX_IE];
		end
	end

	// baud divisor register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			baud_div_r <= fmsp_pkg::BAUD_DIV_RST;
		end else if (ce_i && wr_en && idx == fmsp_pkg::IDX_BAUD_DIV) begin
			baud_div_r <= wb_dat_i[7:0];
		end
	end

	// pending flags: hardware set wins, software writes 0 to clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_pend_r <= fmsp_pkg::CTRL_HIGH_RST[fmsp_pkg::CH_RX_PEND];
			tx_pend_r <= fmsp_pkg::CTRL_LOW_RST[fmsp_pkg::CL_TX_PEND];
		end else if (ce_i) begin
			rx_pend_r <= rx0_set_r | rx_set_r |
				(rx_pend_r & ~(wr_high & ~wb_dat_i[fmsp_pkg::CH_RX_PEND]));
			tx_pend_r <= tx_set_r |
				(tx_pend_r & ~(wr_low & ~wb_dat_i[fmsp_pkg::CL_TX_PEND]));
		end
	end

	// interrupt requests
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_irq_r <= 1'b0;
			tx_irq_r <= 1'b0;
		end else if (ce_i) begin
			rx_irq_r <= rx_pend_r & rx_ie_r;
			tx_irq_r <= tx_pend_r & tx_ie_r;
		end
	end

	// source clock select: clk_i divided by 1, 2, 4 or 8
	always_comb begin
		case (clk_sel_r)
			2'h0: pre_mask = 3'h0;
			2'h1: pre_mask = 3'h1;
			2'h2: pre_mask = 3'h3;
			default: pre_mask = 3'h7;
		endcase
	end
	assign src_tick = (pre_cnt_r & pre_mask) == pre_mask;
	assign div_lim  = (mode_r == fmsp_pkg::MODE_NINE_FIXED) ? fmsp_pkg::FIXED_DIV
		: baud_div_r;
	assign tick16   = src_tick & (div_cnt_r == div_lim);

	// baud tick generator, sixteen ticks per bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_cnt_r <= 3'h0;
			div_cnt_r <= 8'h00;
		end else if (ce_i) begin
			pre_cnt_r <= pre_cnt_r + 3'h1;
			if (src_tick) begin
				div_cnt_r <= (div_cnt_r >= div_lim) ? 8'h00 : div_cnt_r + 8'h01;
			end
		end
	end

	assign tx_bit_end = tick16 & (tx_sub_r == fmsp_pkg::SUB_LAST);

	// transmitter and synchronous shift engine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state_r  <= fmsp_pkg::TX_IDLE;
			tx_sub_r    <= 4'h0;
			tx_bit_r    <= 3'h0;
			tx_shift_r  <= 8'h00;
			sync_rx_r   <= 1'b0;
			sync_samp_r <= 1'b0;
			out_r       <= 1'b1;
			din_o_r     <= 1'b0;
			din_oe_r    <= 1'b0;
			tx_set_r    <= 1'b0;
			rx0_set_r   <= 1'b0;
		end else if (ce_i) begin
			tx_set_r  <= 1'b0;
			rx0_set_r <= 1'b0;
			if (tick16) begin
				tx_sub_r <= tx_sub_r + 4'h1;
			end
			if (tx_go) begin
				tx_shift_r <= wb_dat_i[7:0];
				tx_sub_r   <= 4'h0;
				tx_bit_r   <= 3'h0;
				sync_rx_r  <= 1'b0;
				if (mode_r == fmsp_pkg::MODE_SYNC) begin
					tx_state_r <= fmsp_pkg::TX_SYNC;
				end else begin
					tx_state_r <= fmsp_pkg::TX_START;
				end
			end else begin
				case (tx_state_r)
					fmsp_pkg::TX_IDLE: begin
						out_r    <= 1'b1;
						din_oe_r <= 1'b0;
						if (mode_r == fmsp_pkg::MODE_SYNC && rx_en_r && !rx_pend_r
							&& !rx0_set_r) begin
							tx_state_r <= fmsp_pkg::TX_SYNC;
							sync_rx_r  <= 1'b1;
							tx_sub_r   <= 4'h0;
							tx_bit_r   <= 3'h0;
						end
					end
					fmsp_pkg::TX_START: begin
						out_r <= 1'b0;
						if (tx_bit_end) begin
							tx_state_r <= fmsp_pkg::TX_DATA;
						end
					end
					fmsp_pkg::TX_DATA: begin
						out_r <= tx_shift_r[0];
						if (tx_bit_end) begin
							tx_shift_r <= {1'b0, tx_shift_r[7:1]};
							tx_bit_r   <= tx_bit_r + 3'h1;
							if (tx_bit_r == fmsp_pkg::BIT_LAST) begin
								if (nine_mode) begin
									tx_state_r <= fmsp_pkg::TX_NINTH;
								end else begin
									tx_state_r <= fmsp_pkg::TX_STOP;
									tx_set_r   <= 1'b1;
								end
							end
						end
					end
					fmsp_pkg::TX_NINTH: begin
						out_r <= tb8_r;
						if (tx_bit_end) begin
							tx_state_r <= fmsp_pkg::TX_STOP;
							tx_set_r   <= 1'b1;
						end
					end
					fmsp_pkg::TX_STOP: begin
						out_r <= 1'b1;
						if (tx_bit_end) begin
							tx_state_r <= fmsp_pkg::TX_IDLE;
						end
					end
					fmsp_pkg::TX_SYNC: begin
						out_r    <= tx_sub_r[3];
						din_oe_r <= ~sync_rx_r;
						din_o_r  <= tx_shift_r[0];
						if (tick16 && tx_sub_r == fmsp_pkg::SUB_MID) begin
							sync_samp_r <= serial_in_pin_i;
						end
						if (tx_bit_end) begin
							tx_shift_r <= {sync_rx_r & sync_samp_r, tx_shift_r[7:1]};
							tx_bit_r   <= tx_bit_r + 3'h1;
							if (tx_bit_r == fmsp_pkg::BIT_LAST) begin
								tx_state_r <= fmsp_pkg::TX_IDLE;
								tx_set_r   <= ~sync_rx_r;
								rx0_set_r  <= sync_rx_r;
							end
						end
					end
					default: begin
						tx_state_r <= fmsp_pkg::TX_IDLE;
					end
				endcase
			end
		end
	end

	assign rx_mid = tick16 & (rx_sub_r == fmsp_pkg::SUB_MID);

	// asynchronous receiver, samples at bit midpoints
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_state_r     <= fmsp_pkg::RX_IDLE;
			rx_sub_r       <= 4'h0;
			rx_bit_r       <= 3'h0;
			rx_shift_r     <= 8'h00;
			rx_nine_r      <= 1'b0;
			rx_set_r       <= 1'b0;
			rx_keep_nine_r <= 1'b0;
		end else if (ce_i) begin
			rx_set_r <= 1'b0;
			if (tick16) begin
				rx_sub_r <= rx_sub_r + 4'h1;
			end
			case (rx_state_r)
				fmsp_pkg::RX_IDLE: begin
					if (rx_en_r && mode_r != fmsp_pkg::MODE_SYNC && !serial_in_pin_i) begin
						rx_state_r <= fmsp_pkg::RX_START;
						rx_sub_r   <= 4'h0;
						rx_bit_r   <= 3'h0;
					end
				end
				fmsp_pkg::RX_START: begin
					if (rx_mid) begin
						rx_state_r <= serial_in_pin_i ? fmsp_pkg::RX_IDLE
							: fmsp_pkg::RX_DATA;
					end
				end
				fmsp_pkg::RX_DATA: begin
					if (rx_mid) begin
						rx_shift_r <= {serial_in_pin_i, rx_shift_r[7:1]};
						rx_bit_r   <= rx_bit_r + 3'h1;
						if (rx_bit_r == fmsp_pkg::BIT_LAST) begin
							rx_state_r <= nine_mode ? fmsp_pkg::RX_NINTH : fmsp_pkg::RX_STOP;
						end
					end
				end
				fmsp_pkg::RX_NINTH: begin
					if (rx_mid) begin
						// wait out the stop bit, a low ninth bit is no start
						rx_state_r     <= fmsp_pkg::RX_STOP;
						rx_nine_r      <= serial_in_pin_i;
						rx_keep_nine_r <= 1'b1;
						rx_set_r       <= ~mce_r | serial_in_pin_i;
					end
				end
				fmsp_pkg::RX_STOP: begin
					if (rx_mid) begin
						rx_state_r     <= fmsp_pkg::RX_IDLE;
						rx_keep_nine_r <= 1'b0;
						rx_set_r       <= ~nine_mode & (~mce_r | serial_in_pin_i);
					end
				end
				default: begin
					rx_state_r <= fmsp_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// receive buffer, newest character overwrites an unread one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_buf_r <= fmsp_pkg::DATA_BUF_RST;
			rb8_r    <= fmsp_pkg::CTRL_HIGH_RST[fmsp_pkg::CH_RB8];
		end else if (ce_i) begin
			if (rx0_set_r) begin
				rx_buf_r <= tx_shift_r;
			end else if (rx_set_r) begin
				rx_buf_r <= rx_shift_r;
				if (rx_keep_nine_r) begin
					rb8_r <= rx_nine_r;
				end
			end
		end
	end

	assign wb_ack_o           = ack_r;
	assign wb_dat_o           = dat_r;
	assign serial_out_pin_o   = out_r;
	assign serial_in_pin_o    = din_o_r;
	assign serial_in_pin_oe_o = din_oe_r;
	assign rx_irq_o           = rx_irq_r;
	assign tx_irq_o           = tx_irq_r;

endmodule

// ### testbench/fmsp_assertions.sv
// property checker for the four-mode serial port
`timescale 1ns/10ps
module fmsp_assertions (
	// clock, reset, enable
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	// bus
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic        wb_we_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// pins and requests
	input wire logic        serial_out_pin_o,
	input wire logic        serial_in_pin_oe_o,
	input wire logic        rx_irq_o,
	input wire logic        tx_irq_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	wire logic wr  = wb_ack_o && wb_we_i;
	wire logic dwr = wr && wb_sel_i[0] && wb_adr_i[7:2] == fmsp_pkg::IDX_DATA_BUF;
	property p_ack_answer;
		wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_upper_zero;
		wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper data set");
	property p_unmapped;
		wb_ack_o && !wb_we_i && wb_adr_i[7:4] != 4'h5 |-> wb_dat_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
	property p_tx_start;
		dwr |-> ##[1:8] !serial_out_pin_o;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("no transfer start");
	property p_low_phase;
		$fell(serial_out_pin_o) |-> !serial_out_pin_o [*8];
	endproperty
	a_low_phase: assert property (p_low_phase) else $error("low phase short");
	property p_rx_irq_fall;
		$fell(rx_irq_o) |-> $past(wr, 2) || $past(wr, 3);
	endproperty
	a_rx_irq_fall: assert property (p_rx_irq_fall) else $error("rx request dropped");
	property p_tx_irq_fall;
		$fell(tx_irq_o) |-> $past(wr, 2) || $past(wr, 3);
	endproperty
	a_tx_irq_fall: assert property (p_tx_irq_fall) else $error("tx request dropped");
	property p_reset_idle;
		disable iff (1'b0) rst_i |=> serial_out_pin_o && !serial_in_pin_oe_o && !rx_irq_o
			&& !tx_irq_o;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("reset outputs wrong");
	c_data_write: cover property (dwr);
	c_rx_irq: cover property ($rose(rx_irq_o));
	c_oe: cover property ($rose(serial_in_pin_oe_o));
endmodule
bind fmsp_top fmsp_assertions fmsp_assertions_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
	.serial_out_pin_o(serial_out_pin_o), .serial_in_pin_oe_o(serial_in_pin_oe_o),
	.rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o));

// ### testbench/fmsp_remote.sv
// remote serial device model
`timescale 1ns/10ps
module fmsp_remote (
	// clock
	input  wire logic clk_i,
	// lines from the port
	input  wire logic out_line_i,
	input  wire logic pin_data_i,
	// line to the port, pulled high when idle
	output logic      in_line_o
);
	initial in_line_o = 1'b1;
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// async frame: start, data lsb first, stop
	task automatic send(input logic [8:0] d, input int nb, input int bc);
		@(posedge clk_i);
		in_line_o <= 1'b0;
		wait_clk(bc);
		for (int i = 0; i < nb; i++) begin
			in_line_o <= d[i];
			wait_clk(bc);
		end
		in_line_o <= 1'b1;
		wait_clk(bc);
	endtask
	task automatic recv(input int nb, input int bc, output logic [8:0] d, output logic stp);
		d = 9'h0;
		@(negedge out_line_i);
		wait_clk(bc / 2);
		for (int i = 0; i < nb; i++) begin
			wait_clk(bc);
			d[i] = out_line_i;
		end
		wait_clk(bc);
		stp = out_line_i;
	endtask
	// sync mode: data taken on rising shift clock
	task automatic sync_rx(output logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			@(posedge out_line_i);
			d[i] = pin_data_i;
		end
	endtask
	task automatic sync_tx(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			@(negedge out_line_i);
			in_line_o <= d[i];
		end
		@(posedge out_line_i);
		wait_clk(4);
		in_line_o <= 1'b1;
	endtask
endmodule

// ### testbench/tb.sv
// self-checking bench for the four-mode serial port
`timescale 1ns/10ps
module tb;
	logic        clk_i    = 1'b0;
	logic        rst_i    = 1'b1;
	logic        ce_i     = 1'b1;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0]  wb_sel_i = 4'h0;
	logic        wb_we_i  = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic [31:0] wb_dat_o;
	logic [31:0] rd;
	logic        wb_ack_o, pin_o, pin_oe, out_pin, line, rx_irq, tx_irq, stp, n9;
	wire logic   in_pin   = pin_oe ? pin_o : line;
	logic [8:0]  got;
	logic [7:0]  v, s;
	int          num_errors = 0;
	int          tests_run  = 0;
	always #2.5 clk_i = ~clk_i;
	fmsp_top fmsp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
		.serial_in_pin_i(in_pin), .serial_in_pin_o(pin_o), .serial_in_pin_oe_o(pin_oe),
		.serial_out_pin_o(out_pin), .rx_irq_o(rx_irq), .tx_irq_o(tx_irq));
	fmsp_remote fmsp_remote_inst (.clk_i(clk_i), .out_line_i(out_pin), .pin_data_i(in_pin),
		.in_line_o(line));
	function automatic int bit_len(input int m);
		return (m == 2) ? 16 : 32;
	endfunction
	function automatic logic [31:0] frame(input int m, input logic n, input logic [7:0] d);
		return (m > 1) ? {23'h0, n, d} : {24'h0, d};
	endfunction
	function automatic logic [31:0] hi_rx(input int m, input logic n);
		return {24'h0, 2'(m), 3'b010, (n && m > 1), 2'b11};
	endfunction
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
		input logic [3:0] sl);
		@(posedge clk_i);
		wb_adr_i <= a;
		wb_we_i  <= w;
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= sl;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, d, 4'h1);
	endtask
	task automatic rdr(input logic [7:0] a);
		bus(a, 1'b0, 8'h00, 4'h1);
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk_i);
		num_errors++;
		report_and_stop();
	end
	initial begin
		v = 8'($urandom(32'hc24d4f8b));
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rdr(8'h50);
		chk("ctrl_high", 32'h0, rd);
		rdr(8'h54);
		chk("ctrl_low", 32'h0, rd);
		wr(8'h44, v);
		rdr(8'h44);
		chk("unmapped", 32'h0, rd);
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			wr(8'h54, v);
			rdr(8'h54);
			chk("ctrl_low rw", {24'h0, v & 8'hce}, rd);
			v = 8'($urandom) | 8'h40;
			wr(8'h50, v);
			rdr(8'h50);
			chk("ctrl_high rw", {24'h0, v & 8'hfa}, rd);
		end
		wr(8'h50, 8'h00);
		wr(8'h5c, 8'h5a);
		bus(8'h5c, 1'b1, 8'ha5, 4'he);
		rdr(8'h5c);
		chk("baud_div", 32'h5a, rd);
		ce_i <= 1'b0;
		fork
			rdr(8'h5c);
			begin
				repeat (6) @(posedge clk_i);
				ce_i <= 1'b1;
			end
		join
		chk("ce hold", 32'h5a, rd);
		$display("test registers done");
		wr(8'h5c, 8'h01);
		wr(8'h54, 8'h02);
		for (int m = 1; m < 4; m++) begin
			v = 8'($urandom);
			n9 = 1'($urandom);
			wr(8'h50, {2'(m), 2'b00, n9, 3'b000});
			fork
				fmsp_remote_inst.recv(m > 1 ? 9 : 8, bit_len(m), got, stp);
				wr(8'h58, v);
			join
			chk("tx frame", frame(m, n9, v), {23'h0, got});
			chk("tx stop", 32'h1, {31'h0, stp});
			fmsp_remote_inst.wait_clk(bit_len(m));
			rdr(8'h54);
			chk("tx pending", 32'h3, rd);
			chk("tx irq", 32'h1, {31'h0, tx_irq});
			wr(8'h54, 8'h02);
			rdr(8'h54);
			chk("tx clear", 32'h2, rd);
		end
		$display("test async transmit done");
		wr(8'h54, 8'h00);
		for (int m = 1; m < 4; m++) begin
			v = 8'($urandom);
			n9 = 1'($urandom);
			wr(8'h50, {2'(m), 6'h12});
			fmsp_remote_inst.send({n9, v}, m > 1 ? 9 : 8, bit_len(m));
			rdr(8'h58);
			chk("rx data", {24'h0, v}, rd);
			rdr(8'h50);
			chk("rx ctrl", hi_rx(m, n9), rd);
			chk("rx irq", 32'h1, {31'h0, rx_irq});
		end
		$display("test async receive done");
		wr(8'h50, 8'hb2);
		fmsp_remote_inst.send({1'b0, v}, 9, 16);
		rdr(8'h50);
		chk("filtered", 32'h0, {31'h0, rd[0]});
		for (int i = 0; i < 2; i++) begin
			v = 8'($urandom);
			fmsp_remote_inst.send({1'b1, v}, 9, 16);
		end
		rdr(8'h58);
		chk("overrun data", {24'h0, v}, rd);
		rdr(8'h50);
		chk("overrun ctrl", 32'hb7, rd);
		$display("test filter and overrun done");
		wr(8'h50, 8'h00);
		wr(8'h54, 8'h02);
		v = 8'($urandom);
		fork
			fmsp_remote_inst.sync_rx(s);
			wr(8'h58, v);
		join
		chk("sync tx", {24'h0, v}, {24'h0, s});
		fmsp_remote_inst.wait_clk(32);
		rdr(8'h54);
		chk("sync tx pending", 32'h3, rd);
		v = 8'($urandom);
		fork
			fmsp_remote_inst.sync_tx(v);
			wr(8'h50, 8'h12);
		join
		fmsp_remote_inst.wait_clk(32);
		rdr(8'h58);
		chk("sync rx", {24'h0, v}, rd);
		rdr(8'h50);
		chk("sync rx ctrl", 32'h17, rd);
		$display("test sync done");
		report_and_stop();
	end
endmodule
